// >>> timer_map.svh
// offsets, field positions, reset values and timing counts of the match timer
// assumes a 50 MHz system clock and an 8-bit register port
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CONTROL 8'h04
`define REG_MATCH 8'h05
`define REG_COUNT 8'h06

// ----------------------------------------
// control register fields
// ----------------------------------------
`define BIT_SRC 3
`define BIT_RUN 4
`define BIT_VALID 5
`define BIT_FLAG 6
`define BIT_IRQEN 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define MATCH_RESET 8'h00
`define COUNT_RESET 8'h00
`define READ_IDLE 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define SYS_CLK_HZ 50000000
`define SLOW_CLK_HZ 32768
`define SLOW_DIV (`SYS_CLK_HZ / `SLOW_CLK_HZ)
`define GUARD_CYCLES 2
`define DIV_W 11

`endif

// >>> timer_pkg.sv
// types shared by the match timer and its slow tick divider
// assumes timer_map.svh supplies the widths
`include "timer_map.svh"

package timer_pkg;

  // ----------------------------------------
  // register port request
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // ----------------------------------------
  // modes and states
  // ----------------------------------------
  typedef enum logic [0:0] {
    SRC_SYS = 1'b0,
    SRC_SLOW = 1'b1
  } src_t;

  typedef enum logic [0:0] {
    ST_HALT = 1'b0,
    ST_RUN = 1'b1
  } run_state_t;

  // ----------------------------------------
  // module state
  // ----------------------------------------
  typedef struct packed {
    run_state_t run;
    src_t src;
    logic flag;
    logic irq_en;
    logic [7:0] match;
    logic [7:0] count;
    logic [7:0] rdata;
    logic irq;
  } timer_state_t;

  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
    logic tick;
    logic valid;
  } div_state_t;

endpackage

// >>> slow_tick_divider.sv
// divides the system clock down to the slow timer rate
// assumes one system clock and a synchronous active-low reset
`include "timer_map.svh"

module slow_tick_divider (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick,
  output logic valid
);
  import timer_pkg::*;

  localparam logic [`DIV_W-1:0] LAST = `DIV_W'(`SLOW_DIV - 1);
  localparam logic [`DIV_W-1:0] GUARD_FROM = `DIV_W'(`SLOW_DIV - `GUARD_CYCLES);

  div_state_t s;
  div_state_t next_s;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // valid drops a few cycles before each tick: the count is about to move
  always_comb begin
    next_s = s;
    if (s.cnt == LAST) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + `DIV_W'(1);
    end
    next_s.tick = (s.cnt == LAST);
    next_s.valid = (next_s.cnt < GUARD_FROM);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
  assign valid = s.valid;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_tick_single: assert property (@(posedge clk) disable iff (!reset_n) tick |=> !tick)
    else $error("slow tick longer than one cycle");
  chk_guard_before: assert property (@(posedge clk) disable iff (!reset_n) (s.cnt == LAST) |-> !valid)
    else $error("valid high just before slow tick");

endmodule

// >>> periodic_match_timer_control.sv
// periodic 8-bit match timer: control, count, match value and interrupt
// assumes a single-cycle strobe register port, read data one cycle later
`include "timer_map.svh"

module periodic_match_timer_control (
  input wire logic clk,
  input wire logic reset_n,
  input timer_pkg::bus_req_t req,
  input wire logic stop_mode,
  output logic [7:0] rdata,
  output logic irq
);
  import timer_pkg::*;

  timer_state_t s;
  timer_state_t next_s;
  logic slow_tick;
  logic slow_valid;
  logic tick_now;
  logic wr_control;
  logic wr_match;
  logic wr_count;
  logic rd_control;
  logic rd_count;
  logic rd_match;
  logic flag_clear;
  logic flag_set;
  logic valid_view;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  slow_tick_divider u_div (
    .clk(clk),
    .reset_n(reset_n),
    .tick(slow_tick),
    .valid(slow_valid)
  );

  always_comb begin
    wr_control = req.wr && reg_hit(req.addr, `REG_CONTROL);
    wr_match = req.wr && reg_hit(req.addr, `REG_MATCH);
    wr_count = req.wr && reg_hit(req.addr, `REG_COUNT);
    rd_control = req.rd && reg_hit(req.addr, `REG_CONTROL);
    rd_match = req.rd && reg_hit(req.addr, `REG_MATCH);
    rd_count = req.rd && reg_hit(req.addr, `REG_COUNT);
  end

  // ----------------------------------------
  // timer clock and count view
  // ----------------------------------------
  always_comb begin
    // system clock source advances every cycle, slow one on its tick
    if (s.src == SRC_SLOW) begin
      tick_now = slow_tick;
    end else begin
      tick_now = 1'b1;
    end
    // valid has no meaning on the system clock, so it reads as one
    if (s.src == SRC_SLOW) begin
      valid_view = slow_valid;
    end else begin
      valid_view = 1'b1;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    flag_clear = wr_control && req.wdata[`BIT_FLAG];
    // stop mode is deliberately not looked at here
    flag_set = (s.run == ST_RUN) && tick_now && (s.count == s.match);

    // control register
    if (wr_control) begin
      next_s.irq_en = req.wdata[`BIT_IRQEN];
      if (req.wdata[`BIT_RUN]) begin
        next_s.run = ST_RUN;
      end else begin
        next_s.run = ST_HALT;
      end
      if (s.run == ST_HALT) begin
        next_s.src = src_t'(req.wdata[`BIT_SRC]);
      end
    end

    // counting; halted timer keeps its count
    if ((s.run == ST_RUN) && tick_now) begin
      if (s.count == s.match) begin
        next_s.count = `COUNT_RESET;
      end else begin
        next_s.count = s.count + 8'h01;
      end
    end

    // software load wins over a same-cycle count step
    if (wr_count && (s.src == SRC_SYS)) begin
      next_s.count = req.wdata;
    end
    if (wr_match && (s.src == SRC_SYS)) begin
      next_s.match = req.wdata;
    end

    // set wins over a same-cycle software clear
    next_s.flag = (s.flag && !flag_clear) || flag_set;

    // read data stands for one cycle only
    next_s.rdata = `READ_IDLE;
    if (rd_control) begin
      next_s.rdata = {s.irq_en, s.flag, valid_view, s.run, s.src, 3'b000};
    end else if (rd_match) begin
      next_s.rdata = s.match;
    end else if (rd_count) begin
      if ((s.src == SRC_SLOW) && !slow_valid) begin
        next_s.rdata = 8'h00;
      end else begin
        next_s.rdata = s.count;
      end
    end

    next_s.irq = next_s.flag && next_s.irq_en;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s.run <= ST_HALT;
      s.src <= SRC_SYS;
      s.flag <= 1'b0;
      s.irq_en <= 1'b0;
      s.match <= `MATCH_RESET;
      s.count <= `COUNT_RESET;
      s.rdata <= `READ_IDLE;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign irq = s.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_match_hit;
    (s.run == ST_RUN) && tick_now && (s.count == s.match);
  endsequence

  sequence seq_sys_step;
    (s.run == ST_RUN) && (s.src == SRC_SYS) && !wr_count && (s.count != s.match);
  endsequence

  sequence seq_count_read;
    rd_count ##1 1'b1;
  endsequence

  chk_run_counts: assert property (seq_sys_step |=> s.count == $past(s.count) + 8'h01)
    else $error("running timer did not advance");

  chk_halt_holds: assert property ((s.run == ST_HALT) && !wr_count |=> $stable(s.count))
    else $error("halted timer count moved");

  chk_stop_ignored: assert property (stop_mode ##0 seq_sys_step |=> s.count != $past(s.count))
    else $error("timer halted in stop mode");

  chk_valid_read: assert property (
    rd_count && (s.src == SRC_SLOW) && slow_valid ##1 1'b1 |-> rdata == $past(s.count))
    else $error("valid slow read returned wrong count");

  chk_invalid_zero: assert property (rd_count && (s.src == SRC_SLOW) && !slow_valid |=> rdata == 8'h00)
    else $error("invalid slow read not zero");

  chk_sys_read: assert property (rd_count && (s.src == SRC_SYS) |=> rdata == $past(s.count))
    else $error("system clock read returned wrong count");

  chk_read_once: assert property (seq_count_read |=> rdata == 8'h00 || $past(req.rd))
    else $error("read data held past its cycle");

  chk_match_sets: assert property (seq_match_hit |=> s.flag)
    else $error("match did not set flag");

  chk_flag_sticky: assert property (s.flag && !flag_clear |=> s.flag)
    else $error("flag cleared without software");

  chk_irq_gate: assert property (!s.irq_en |-> !irq)
    else $error("interrupt with enable clear");

  chk_irq_raise: assert property (s.flag && s.irq_en |-> irq)
    else $error("enabled flag gave no interrupt");

  chk_src_locked: assert property ((s.run == ST_RUN) |=> $stable(s.src))
    else $error("source changed while running");

  chk_match_locked: assert property ((s.src == SRC_SLOW) |=> $stable(s.match))
    else $error("match value written on slow source");

  chk_count_locked: assert property (wr_count && (s.src == SRC_SLOW) && (s.run == ST_HALT) |=> $stable(s.count))
    else $error("count written on slow source");

  chk_wrap_zero: assert property (seq_match_hit ##0 !wr_count |=> s.count == 8'h00)
    else $error("count did not restart after match");

endmodule

// >>> periodic_match_timer_control_tb_top.sv
// self-checking bench of the periodic match timer: register port, irq, stop mode
// assumes timer_pkg and timer_map.svh are compiled first, one 50 MHz clock
`include "timer_map.svh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e); end end

module periodic_match_timer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  logic clk;
  logic reset_n;
  logic stop_mode;
  logic irq;
  logic [7:0] rdata;
  logic [7:0] got;
  bus_req_t req;
  int mismatches = 0;
  int checks_done = 0;
  logic [15:0] seed = 16'h6173;

  periodic_match_timer_control i_dut (.clk(clk), .reset_n(reset_n), .req(req), .stop_mode(stop_mode),
    .rdata(rdata), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd8();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  // expected control byte, built from its fields
  function automatic logic [7:0] ctl_byte(input logic ie, input logic fl, input logic vl, input logic rn,
    input logic sc);
    logic [7:0] b;
    b = 8'h00;
    b[`BIT_IRQEN] = ie;
    b[`BIT_FLAG] = fl;
    b[`BIT_VALID] = vl;
    b[`BIT_RUN] = rn;
    b[`BIT_SRC] = sc;
    return b;
  endfunction

  // one gap cycle after each strobe keeps a signal from being driven twice in a step
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    got = rdata;
  endtask

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (irq !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: irq never rose", $time);
      conclude();
    end
  endtask

  task automatic test_done(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("totals: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] mv;
    logic [7:0] cv;
    int n;
    int zeros;
    int olds;
    int steps;
    int bad;
    req = '0;
    stop_mode = 1'b0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    bus_rd(`REG_MATCH);
    `CHK(got, 8'h00, "match reset");
    bus_rd(`REG_COUNT);
    `CHK(got, 8'h00, "count reset");
    bus_wr(8'h00, 8'hFF);
    bus_rd(8'h00);
    `CHK(got, 8'h00, "unmapped read");
    bus_rd(`REG_CONTROL);
    `CHK(got, ctl_byte(1'b0, 1'b0, 1'b1, 1'b0, 1'b0), "control reset");
    repeat (4) begin
      mv = rnd8();
      cv = rnd8();
      bus_wr(`REG_MATCH, mv);
      bus_wr(`REG_COUNT, cv);
      bus_rd(`REG_MATCH);
      `CHK(got, mv, "match readback");
      bus_rd(`REG_COUNT);
      `CHK(got, cv, "count readback");
    end
    test_done("registers");
    // short match keeps the period small, random so the wrap point moves
    mv = (rnd8() & 8'h07) + 8'h03;
    bus_wr(`REG_MATCH, mv);
    bus_wr(`REG_COUNT, 8'h00);
    bus_wr(`REG_CONTROL, 8'h10);
    stop_mode <= 1'b1;
    repeat (8) begin
      bus_rd(`REG_COUNT);
      `CHK(got <= mv, 1'b1, "count above match");
      `CHK(irq, 1'b0, "irq while disabled");
    end
    bus_rd(`REG_CONTROL);
    `CHK(got[`BIT_FLAG], 1'b1, "flag after match");
    `CHK(got[`BIT_RUN], 1'b1, "run in stop mode");
    // halt first: a match in the clearing cycle would set the flag again
    bus_wr(`REG_CONTROL, 8'h00);
    bus_wr(`REG_CONTROL, 8'h40);
    bus_wr(`REG_COUNT, 8'h00);
    bus_wr(`REG_CONTROL, 8'h90);
    wait_irq(mv + 8, n);
    `CHK(n >= mv && n <= mv + 2, 1'b1, "match period");
    bus_wr(`REG_CONTROL, 8'h80);
    bus_rd(`REG_COUNT);
    cv = got;
    repeat (40) @(posedge clk);
    bus_rd(`REG_COUNT);
    `CHK(got, cv, "count held when halted");
    `CHK(irq, 1'b1, "flag kept");
    bus_wr(`REG_CONTROL, 8'hC0);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0, "flag cleared");
    stop_mode <= 1'b0;
    test_done("match");
    bus_wr(`REG_CONTROL, 8'h10);
    bus_wr(`REG_CONTROL, 8'h18);
    bus_rd(`REG_CONTROL);
    `CHK(got[`BIT_SRC], 1'b0, "source locked while running");
    bus_wr(`REG_CONTROL, 8'h00);
    // high and odd: never zero, never near the match value, no wrap in two ticks
    cv = (rnd8() & 8'h3F) | 8'h81;
    bus_wr(`REG_COUNT, cv);
    bus_wr(`REG_CONTROL, 8'h08);
    bus_rd(`REG_CONTROL);
    `CHK(got[`BIT_SRC], 1'b1, "source set while halted");
    bus_wr(`REG_COUNT, ~cv);
    bus_wr(`REG_MATCH, ~mv);
    bus_rd(`REG_MATCH);
    `CHK(got, mv, "match write on slow source");
    zeros = 0;
    olds = 0;
    // back-to-back reads every 2 cycles cannot step over the 2-cycle invalid window
    repeat (1600) begin
      bus_rd(`REG_COUNT);
      if (got === cv) begin
        olds++;
      end else if (got === 8'h00) begin
        zeros++;
      end
    end
    `CHK(olds + zeros, 1600, "count read on slow source");
    `CHK(olds > 0, 1'b1, "true count when valid");
    `CHK(zeros > 0, 1'b1, "zero when invalid");
    // run on the slow source: a little over one slow period, so one or two ticks
    bus_wr(`REG_CONTROL, 8'h18);
    steps = 0;
    bad = 0;
    repeat (800) begin
      bus_rd(`REG_COUNT);
      if (got === cv + 8'h01) begin
        steps++;
      end else if (got !== cv && got !== cv + 8'h02 && got !== 8'h00) begin
        bad++;
      end
    end
    `CHK(bad, 0, "slow count off its path");
    `CHK(steps > 0, 1'b1, "no step on slow source");
    test_done("slow source");
    // reset in mid-run, timer running on the slow source
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    bus_rd(`REG_MATCH);
    `CHK(got, `MATCH_RESET, "match after reset");
    bus_rd(`REG_COUNT);
    `CHK(got, `COUNT_RESET, "count after reset");
    bus_rd(`REG_CONTROL);
    `CHK(got, ctl_byte(1'b0, 1'b0, 1'b1, 1'b0, 1'b0), "control after reset");
    `CHK(irq, 1'b0, "irq after reset");
    test_done("reset");
    conclude();
  end
endmodule
